// [dmsd_consts.svh]
// Constants for the data memory space decoder: boundaries, pin reset levels, bus cycle timing
`ifndef DMSD_CONSTS_SVH
`define DMSD_CONSTS_SVH

// Highest byte that can be reached by both direct and indirect addressing
`define DMSD_LOWER_TOP        8'h7f
// Last expanded RAM byte for the small and the large variant
`define DMSD_XRAM_TOP_SMALL   16'h01ff
`define DMSD_XRAM_TOP_LARGE   16'h02ff
// Reset levels of the multiplexed and the high address port
`define DMSD_AD_RESET         8'hff
`define DMSD_HIGH_RESET       8'hff
// Strobe low time of an external cycle, in clock cycles
`define DMSD_STROBE_CYCLES    2'h3

`endif

// [dmsd_pkg.sv]
// Types shared by the data memory space decoder and its pin synchroniser
package dmsd_pkg;

    // Addressing form of the access offered by the execution unit
    typedef enum logic [2:0] {
        DMSD_MODE_DIRECT,
        DMSD_MODE_INDIRECT,
        DMSD_MODE_XMOVE_RI,
        DMSD_MODE_XMOVE_SIXTEEN_BIT_DATA_POINTER,
        DMSD_MODE_STACK
    } dmsd_mode_t;

    // Where one access ends up
    typedef enum logic [2:0] {
        DMSD_TGT_NONE,
        DMSD_TGT_LOWER,
        DMSD_TGT_UPPER,
        DMSD_TGT_SPECIAL,
        DMSD_TGT_XRAM,
        DMSD_TGT_EXT
    } dmsd_tgt_t;

    // External cycle sequencer
    typedef enum logic [1:0] {
        DMSD_ST_IDLE,
        DMSD_ST_ADDR,
        DMSD_ST_STROBE,
        DMSD_ST_HOLD
    } dmsd_state_t;

    // Request from the execution unit
    typedef struct packed {
        logic        valid;
        dmsd_mode_t  mode;
        logic        write;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } dmsd_req_t;

    // One-cycle selects towards the on-chip storage
    typedef struct packed {
        logic        lower_sel;
        logic        upper_sel;
        logic        special_sel;
        logic        xram_sel;
        logic        write;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } dmsd_mem_t;

    // External bus pins
    typedef struct packed {
        logic [7:0] ad_out;
        logic       ad_oe_n;
        logic [7:0] high_out;
        logic       ale;
        logic       wr_n;
        logic       rd_n;
    } dmsd_pins_t;

    // Whole state of the decoder
    typedef struct packed {
        dmsd_state_t st;
        logic [1:0]  cnt;
        dmsd_req_t   req;
        dmsd_mem_t   mem;
        dmsd_pins_t  pins;
        logic        busy;
        logic        done;
        logic [7:0]  rdata;
    } dmsd_regs_t;

endpackage : dmsd_pkg

// [dmsd_sync.sv]
// Two-stage synchroniser for the multiplexed address/data port input
`timescale 1ns/1ps
module dmsd_sync
    import dmsd_pkg::*;
(
    input  wire logic       clock,
    input  wire logic       rst_n,
    input  wire logic [7:0] pin_in,
    output logic [7:0]      pin_sync
);
    typedef struct packed {
        logic [7:0] meta;
        logic [7:0] stable;
    } dmsd_sync_t;

    dmsd_sync_t q_ff;
    dmsd_sync_t nxt_q;

    // First stage feeds only the second stage; one process keeps a single writer of nxt_q
    always_comb begin
        nxt_q.meta   = pin_in;
        nxt_q.stable = q_ff.meta;
    end

    // Pins are pulled high when idle, so reset to ones
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            q_ff <= {8'hff, 8'hff};
        end else begin
            q_ff <= nxt_q;
        end
    end

    assign pin_sync = q_ff.stable;

endmodule : dmsd_sync

// [dmsd_decoder.sv]
// Data memory space decoder: steers each access to on-chip storage or the external bus
`timescale 1ns/1ps
`include "dmsd_consts.svh"

module dmsd_decoder
    import dmsd_pkg::*;
#(
    parameter bit XRAM_LARGE = 1'b0
) (
    input  wire logic       clock,
    input  wire logic       rst_n,
    input  dmsd_req_t       req,
    input  wire logic       onchip_xram_disable,
    input  wire logic [7:0] p2_latch,
    input  wire logic [7:0] ad_in,
    output dmsd_mem_t       mem,
    output dmsd_pins_t      pins,
    output logic            busy,
    output logic            done,
    output logic [7:0]      rdata
);
    localparam logic [15:0] XRAM_TOP = XRAM_LARGE ? `DMSD_XRAM_TOP_LARGE : `DMSD_XRAM_TOP_SMALL;

    dmsd_regs_t q_ff;
    dmsd_regs_t nxt_q;
    logic [7:0] ad_sync;
    logic       accept;
    dmsd_tgt_t  tgt;

    // Target of one access; shared by the sequencer and its checks
    function automatic dmsd_tgt_t dmsd_decode(input dmsd_mode_t mode, input logic [15:0] addr,
                                              input logic dis);
        dmsd_tgt_t t;
        t = DMSD_TGT_NONE;
        unique case (mode)
            DMSD_MODE_DIRECT:     t = (addr[7:0] > `DMSD_LOWER_TOP) ? DMSD_TGT_SPECIAL : DMSD_TGT_LOWER;
            DMSD_MODE_INDIRECT,
            DMSD_MODE_STACK:      t = (addr[7:0] > `DMSD_LOWER_TOP) ? DMSD_TGT_UPPER : DMSD_TGT_LOWER;
            DMSD_MODE_XMOVE_RI:   t = dis ? DMSD_TGT_EXT : DMSD_TGT_XRAM;
            DMSD_MODE_XMOVE_SIXTEEN_BIT_DATA_POINTER: t = (!dis && addr <= XRAM_TOP) ? DMSD_TGT_XRAM : DMSD_TGT_EXT;
            default:              t = DMSD_TGT_NONE;
        endcase
        return t;
    endfunction : dmsd_decode

    dmsd_sync u_ad_sync (
        .clock    (clock),
        .rst_n    (rst_n),
        .pin_in   (ad_in),
        .pin_sync (ad_sync)
    );

    assign accept = req.valid && !q_ff.busy;
    // Disable bit read at the moment each access is taken
    assign tgt    = dmsd_decode(req.mode, req.addr, onchip_xram_disable);

    // Next state: pulses fall back each cycle, the sequencer walks the bus cycle
    always_comb begin
        nxt_q                 = q_ff;
        nxt_q.mem.lower_sel   = 1'b0;
        nxt_q.mem.upper_sel   = 1'b0;
        nxt_q.mem.special_sel = 1'b0;
        nxt_q.mem.xram_sel    = 1'b0;
        nxt_q.done            = 1'b0;
        unique case (q_ff.st)
            DMSD_ST_IDLE: begin
                nxt_q.pins.high_out = p2_latch;
                if (accept) begin
                    nxt_q.mem.write = req.write;
                    nxt_q.mem.addr  = req.addr;
                    nxt_q.mem.wdata = req.wdata;
                    nxt_q.req       = req;
                    // Separate selects keep the two 80H-FFH stores apart
                    unique case (tgt)
                        DMSD_TGT_LOWER:   nxt_q.mem.lower_sel   = 1'b1;
                        DMSD_TGT_UPPER:   nxt_q.mem.upper_sel   = 1'b1;
                        DMSD_TGT_SPECIAL: nxt_q.mem.special_sel = 1'b1;
                        DMSD_TGT_XRAM:    nxt_q.mem.xram_sel    = 1'b1;
                        DMSD_TGT_EXT:     ;
                        DMSD_TGT_NONE:    ;
                    endcase
                    if (tgt == DMSD_TGT_EXT) begin
                        // Address phase: low byte muxed on the bus port
                        nxt_q.st           = DMSD_ST_ADDR;
                        nxt_q.busy         = 1'b1;
                        nxt_q.pins.ale     = 1'b1;
                        nxt_q.pins.ad_out  = req.addr[7:0];
                        nxt_q.pins.ad_oe_n = 1'b0;
                        if (req.mode == DMSD_MODE_XMOVE_SIXTEEN_BIT_DATA_POINTER) begin
                            nxt_q.pins.high_out = req.addr[15:8];
                        end
                    end else begin
                        nxt_q.done = 1'b1;
                    end
                end
            end
            DMSD_ST_ADDR: begin
                nxt_q.st       = DMSD_ST_STROBE;
                nxt_q.pins.ale = 1'b0;
                nxt_q.cnt      = `DMSD_STROBE_CYCLES - 2'h1;
                if (q_ff.req.write) begin
                    nxt_q.pins.ad_out = q_ff.req.wdata;
                    nxt_q.pins.wr_n   = 1'b0;
                end else begin
                    // Release the port so the far side can drive read data
                    nxt_q.pins.ad_oe_n = 1'b1;
                    nxt_q.pins.rd_n    = 1'b0;
                end
            end
            DMSD_ST_STROBE: begin
                if (q_ff.cnt == 2'h0) begin
                    nxt_q.st        = DMSD_ST_HOLD;
                    nxt_q.pins.wr_n = 1'b1;
                    nxt_q.pins.rd_n = 1'b1;
                end else begin
                    nxt_q.cnt = q_ff.cnt - 2'h1;
                end
            end
            DMSD_ST_HOLD: begin
                // Synchronised port still shows the value seen under the strobe
                if (!q_ff.req.write) begin
                    nxt_q.rdata = ad_sync;
                end
                nxt_q.st            = DMSD_ST_IDLE;
                nxt_q.busy          = 1'b0;
                nxt_q.done          = 1'b1;
                nxt_q.pins.ad_oe_n  = 1'b1;
                nxt_q.pins.high_out = p2_latch;
            end
        endcase
    end

    // Bus idles with strobes high and the port released
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            q_ff                <= '0;
            q_ff.st             <= DMSD_ST_IDLE;
            q_ff.pins.ad_out    <= `DMSD_AD_RESET;
            q_ff.pins.ad_oe_n   <= 1'b1;
            q_ff.pins.high_out  <= `DMSD_HIGH_RESET;
            q_ff.pins.wr_n      <= 1'b1;
            q_ff.pins.rd_n      <= 1'b1;
        end else begin
            q_ff <= nxt_q;
        end
    end

    assign mem   = q_ff.mem;
    assign pins  = q_ff.pins;
    assign busy  = q_ff.busy;
    assign done  = q_ff.done;
    assign rdata = q_ff.rdata;

    // Checks on the routing and on the external cycle
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    sequence s_addr_phase;
        q_ff.pins.ale && !q_ff.pins.ad_oe_n && q_ff.pins.wr_n && q_ff.pins.rd_n;
    endsequence

    sequence s_write_strobe;
        (!q_ff.pins.wr_n && q_ff.pins.rd_n) [*3];
    endsequence

    sequence s_read_strobe;
        (!q_ff.pins.rd_n && q_ff.pins.wr_n && q_ff.pins.ad_oe_n) [*3];
    endsequence

    // Routing is seen one edge after the taking edge; bus cycle is latch, three strobes, hold, done
    a_low_both_modes: assert property ((accept && req.addr[7:0] <= `DMSD_LOWER_TOP &&
        (req.mode == DMSD_MODE_DIRECT || req.mode == DMSD_MODE_INDIRECT)) |=> q_ff.mem.lower_sel && q_ff.done)
        else $error("low byte not routed to lower RAM");
    a_indirect_upper: assert property ((accept && req.mode == DMSD_MODE_INDIRECT && req.addr[7])
        |=> q_ff.mem.upper_sel && !q_ff.mem.special_sel)
        else $error("indirect high byte not routed to upper RAM");
    a_direct_special: assert property ((accept && req.mode == DMSD_MODE_DIRECT && req.addr[7])
        |=> q_ff.mem.special_sel && !q_ff.mem.upper_sel && q_ff.mem.addr[7:0] == $past(req.addr[7:0]))
        else $error("direct high byte not routed to special registers");
    a_store_apart: assert property (!(q_ff.mem.upper_sel && q_ff.mem.special_sel))
        else $error("upper RAM and special registers selected together");
    a_xram_quiet: assert property (q_ff.mem.xram_sel |->
        q_ff.pins.ad_oe_n && q_ff.pins.wr_n && q_ff.pins.rd_n && !q_ff.busy)
        else $error("expanded RAM access disturbed the bus");
    a_ri_xram: assert property ((accept && !onchip_xram_disable && req.mode == DMSD_MODE_XMOVE_RI)
        |=> q_ff.mem.xram_sel)
        else $error("pointer move missed expanded RAM");
    a_stack_internal: assert property ((accept && req.mode == DMSD_MODE_STACK)
        |=> !q_ff.mem.xram_sel && !q_ff.busy && (q_ff.mem.lower_sel || q_ff.mem.upper_sel))
        else $error("stack access left internal RAM");
    a_sixteen_bit_data_pointer_write_cycle: assert property ((accept && tgt == DMSD_TGT_EXT && req.write &&
        req.mode == DMSD_MODE_XMOVE_SIXTEEN_BIT_DATA_POINTER) |=> (s_addr_phase and (q_ff.pins.high_out == $past(req.addr[15:8])))
        ##1 s_write_strobe ##1 (q_ff.pins.wr_n && !q_ff.pins.ad_oe_n) ##1 q_ff.done)
        else $error("external write cycle malformed");
    a_ext_read_cycle: assert property ((accept && tgt == DMSD_TGT_EXT && !req.write)
        |=> s_addr_phase ##1 s_read_strobe ##1 (q_ff.pins.rd_n && q_ff.busy) ##1 (q_ff.done && !q_ff.busy))
        else $error("external read cycle malformed");
    a_high_latch: assert property ((q_ff.st == DMSD_ST_ADDR &&
        q_ff.req.mode == DMSD_MODE_XMOVE_RI) |-> q_ff.pins.high_out == $past(p2_latch))
        else $error("high port not showing the latch");
    a_sixteen_bit_data_pointer_above: assert property ((accept && !onchip_xram_disable &&
        req.mode == DMSD_MODE_XMOVE_SIXTEEN_BIT_DATA_POINTER && req.addr > XRAM_TOP) |=> q_ff.busy && !q_ff.mem.xram_sel)
        else $error("pointer move above expanded RAM stayed on chip");
    a_strobe_apart: assert property (!(!q_ff.pins.wr_n && !q_ff.pins.rd_n))
        else $error("write and read strobes low together");

endmodule : dmsd_decoder

// [dmsd_xmem_model.sv]
// Behavioural external data memory on the multiplexed bus, far side of the decoder
`timescale 1ns/1ps
module dmsd_xmem_model
    import dmsd_pkg::*;
(
    input  wire logic  clock,
    input  wire logic  rst_n,
    input  dmsd_pins_t pins,
    output logic [7:0] drv
);
    logic [15:0] addr_ff;
    logic [7:0]  store_ff [256];
    logic [7:0]  drv_ff;

    // Latch address on the latch pulse, high byte from the high port
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            addr_ff <= 16'h0000;
        end else if (pins.ale) begin
            addr_ff <= {pins.high_out, pins.ad_out};
        end
    end

    // Store while the write strobe is low; data is muxed on the same port
    always_ff @(posedge clock) begin
        if (rst_n && !pins.wr_n) begin
            store_ff[addr_ff[7:0]] <= pins.ad_out;
        end
    end

    // Released bus shows the inverse of the last value, never a stale copy
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            drv_ff <= 8'hff;
        end else if (!pins.rd_n) begin
            drv_ff <= store_ff[addr_ff[7:0]];
        end else begin
            drv_ff <= ~drv_ff;
        end
    end
    assign drv = drv_ff;
endmodule : dmsd_xmem_model

// [tb.sv]
// Self-checking testbench for the data memory space decoder
`timescale 1ns/1ps
module tb
    import dmsd_pkg::*;
;
    logic        clock = 1'b0;
    logic        rst_n = 1'b0;
    dmsd_req_t   req   = '0;
    logic        dis   = 1'b1;
    logic [7:0]  p2    = 8'h3c;
    logic [7:0]  drv;
    wire  [7:0]  ad_bus;
    dmsd_mem_t   mem;
    dmsd_pins_t  pins;
    logic        busy;
    logic        done;
    logic [7:0]  rdata;
    int          err_total;
    int          comparisons;
    logic [3:0]  sel_seen;
    logic [7:0]  ale_lo;
    logic [7:0]  ale_hi;
    int          wr_low;
    int          rd_low;
    logic        oe_seen;
    int          busy_cnt;

    always #12.5 clock = ~clock;
    // Bus level: the decoder wins while its enable is low
    assign ad_bus = pins.ad_oe_n ? drv : pins.ad_out;

    dmsd_decoder #(.XRAM_LARGE(1'b0)) u_dmsd_decoder (.clock(clock), .rst_n(rst_n), .req(req),
        .onchip_xram_disable(dis), .p2_latch(p2), .ad_in(ad_bus), .mem(mem), .pins(pins),
        .busy(busy), .done(done), .rdata(rdata));
    dmsd_xmem_model u_dmsd_xmem_model (.clock(clock), .rst_n(rst_n), .pins(pins), .drv(drv));

    task chk(string what, logic [15:0] exp, logic [15:0] got);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // One access, watching every cycle until done; bounded wait
    task access(dmsd_mode_t m, logic w, logic [15:0] a, logic [7:0] d);
        int n;
        sel_seen = '0;
        wr_low = 0;
        rd_low = 0;
        oe_seen = 1'b0;
        busy_cnt = 0;
        ale_lo = '0;
        ale_hi = '0;
        @(posedge clock);
        req <= '{1'b1, m, w, a, d};
        @(posedge clock);
        req.valid <= 1'b0;
        for (n = 0; n < 20; n++) begin
            #1;
            sel_seen |= {mem.lower_sel, mem.upper_sel, mem.special_sel, mem.xram_sel};
            if (pins.ale === 1'b1) begin
                ale_lo = pins.ad_out;
                ale_hi = pins.high_out;
            end
            if (pins.wr_n === 1'b0) wr_low++;
            if (pins.rd_n === 1'b0) rd_low++;
            if (pins.ad_oe_n === 1'b0) oe_seen = 1'b1;
            if (busy === 1'b1) busy_cnt++;
            if (done === 1'b1) break;
            @(posedge clock);
        end
        chk("done", 16'h0001, {15'h0000, done});
    endtask : access

    // Internal access: expected select set {lower, upper, special, xram}
    task t_int(dmsd_mode_t m, logic [15:0] a, logic [3:0] exp_sel);
        access(m, 1'b0, a, 8'h00);
        chk("selects", {12'h000, exp_sel}, {12'h000, sel_seen});
        chk("strobes", 16'h0000, 16'(wr_low + rd_low));
        chk("mem addr", a, mem.addr);
        chk("busy cycles", 16'h0000, 16'(busy_cnt));
    endtask : t_int

    // Pin idle levels and the high port following the latch
    task test_idle;
        p2 <= 8'h5c;
        repeat (2) @(posedge clock);
        #1;
        chk("high port", 16'h005c, {8'h00, pins.high_out});
        chk("idle pins", 16'h0007, {13'h0000, pins.ad_oe_n, pins.wr_n, pins.rd_n});
        $display("test_idle finished");
    endtask : test_idle

    task test_internal;
        t_int(DMSD_MODE_DIRECT, 16'h007f, 4'b1000);
        t_int(DMSD_MODE_INDIRECT, 16'h0000, 4'b1000);
        t_int(DMSD_MODE_DIRECT, 16'h0080, 4'b0010);
        t_int(DMSD_MODE_INDIRECT, 16'h00ff, 4'b0100);
        t_int(DMSD_MODE_DIRECT, 16'h00a0, 4'b0010);
        t_int(DMSD_MODE_INDIRECT, 16'h00a0, 4'b0100);
        t_int(DMSD_MODE_STACK, 16'h00ff, 4'b0100);
        t_int(DMSD_MODE_STACK, 16'h017f, 4'b1000);
        // Internal store: write flag and data travel with the select
        access(DMSD_MODE_INDIRECT, 1'b1, 16'h0090, 8'hc3);
        chk("selects", 16'h0004, {12'h000, sel_seen});
        chk("mem wdata", 16'h01c3, {7'h00, mem.write, mem.wdata});
        $display("test_internal finished");
    endtask : test_internal

    // Disable clear: on-chip hits leave the bus alone, above range goes out
    task test_xram;
        @(posedge clock);
        dis <= 1'b0;
        t_int(DMSD_MODE_XMOVE_RI, 16'h00a0, 4'b0001);
        chk("bus enable", 16'h0000, {15'h0000, oe_seen});
        t_int(DMSD_MODE_XMOVE_SIXTEEN_BIT_DATA_POINTER, 16'h01ff, 4'b0001);
        access(DMSD_MODE_XMOVE_SIXTEEN_BIT_DATA_POINTER, 1'b1, 16'h0200, 8'h77);
        chk("ext sel", 16'h0000, {12'h000, sel_seen});
        chk("ext addr", 16'h0200, {ale_hi, ale_lo});
        chk("wr width", 16'h0003, 16'(wr_low));
        // Latch cycle, three strobe cycles and one hold cycle
        chk("busy cycles", 16'h0005, 16'(busy_cnt));
        $display("test_xram finished");
    endtask : test_xram

    // Disable set: both pointer forms run bus cycles; disable sampled per access
    task test_ext;
        @(posedge clock);
        dis <= 1'b1;
        p2 <= 8'h3c;
        access(DMSD_MODE_XMOVE_SIXTEEN_BIT_DATA_POINTER, 1'b1, 16'h1234, 8'h5a);
        chk("sixteen_bit_data_pointer addr", 16'h1234, {ale_hi, ale_lo});
        chk("wr/rd strobes", 16'h0300, {8'(wr_low), 8'(rd_low)});
        access(DMSD_MODE_XMOVE_SIXTEEN_BIT_DATA_POINTER, 1'b0, 16'h1234, 8'h00);
        chk("wr/rd strobes", 16'h0003, {8'(wr_low), 8'(rd_low)});
        chk("sixteen_bit_data_pointer rdata", 16'h005a, {8'h00, rdata});
        access(DMSD_MODE_XMOVE_RI, 1'b1, 16'h00a0, 8'ha5);
        chk("ri addr", 16'h3ca0, {ale_hi, ale_lo});
        chk("ri sel", 16'h0000, {12'h000, sel_seen});
        access(DMSD_MODE_XMOVE_RI, 1'b0, 16'h00a0, 8'h00);
        chk("ri rdata", 16'h00a5, {8'h00, rdata});
        @(posedge clock);
        dis <= 1'b0;
        t_int(DMSD_MODE_XMOVE_RI, 16'h00a0, 4'b0001);
        $display("test_ext finished");
    endtask : test_ext

    task tally_and_finish;
        $display("Counts: comparisons=%0d err_total=%0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : tally_and_finish

    // Whole run is under a hundred cycles; a hang ends at 3000 cycles, well after this
    initial begin
        repeat (3000) @(posedge clock);
        err_total++;
        tally_and_finish();
    end

    initial begin
        repeat (6) @(posedge clock);
        rst_n <= 1'b1;
        test_idle();
        test_internal();
        test_xram();
        test_ext();
        tally_and_finish();
    end
endmodule : tb
